// *** bir_params.svh ***
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH

// ==========================================================
// configuration offsets and reset values
`define BIR_OFF_ROUTE_FIRST  8'h70
`define BIR_OFF_ROUTE_SECOND 8'h71
`define BIR_ROUTE_RST        8'h80
`define BIR_READ_NONE        8'h00

// ==========================================================
// routing register fields
`define BIR_EN_N_BIT   7
`define BIR_SHARE_BIT  6
`define BIR_IRQ0_BIT   5
`define BIR_RSV_BIT    4
`define BIR_CODE_HI    3
`define BIR_CODE_LO    0

// ==========================================================
// request inputs that a route may target: 3-7, 9-12, 14, 15
`define BIR_CODE_VALID 16'hDEF8
`define BIR_ONE_HOT    16'h0001
`define BIR_VEC_ZERO   16'h0000
`define BIR_IRQ0_IDX   0
`define BIR_IRQ15_IDX  15

`endif

// *** bir_pkg.sv ***
// ==========================================================
// shared types
package bir_pkg;
   typedef logic [7:0]  bir_route_t;
   typedef logic [15:0] bir_irq_vec_t;
   typedef logic [3:0]  bir_code_t;
endpackage : bir_pkg

// *** bir_route_dec.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "bir_params.svh"

// ==========================================================
// decode of one routing register into target, drive and mask
module bir_route_dec (
   // routing register value
   input  wire bir_pkg::bir_route_t   route,
   // synchronised board interrupt level, already gated if absent
   input  wire logic                  irq_in,
   // request inputs that pci steering also uses
   input  wire bir_pkg::bir_irq_vec_t pci_hit,
   // decoded results
   output wire bir_pkg::bir_irq_vec_t target,
   output wire bir_pkg::bir_irq_vec_t drive,
   output wire bir_pkg::bir_irq_vec_t isa_mask
);

   // one-hot of the coded request input, reserved codes give nothing
   wire bir_pkg::bir_code_t   code_w;
   wire bir_pkg::bir_irq_vec_t onehot_w;
   wire                       en_w;
   wire                       share_w;

   assign code_w   = route[`BIR_CODE_HI:`BIR_CODE_LO];
   assign onehot_w = `BIR_ONE_HOT << code_w;                       // [R12]
   assign en_w     = ~route[`BIR_EN_N_BIT];                          // [R03]
   assign share_w  = route[`BIR_SHARE_BIT];
   assign target   = en_w ? (onehot_w & `BIR_CODE_VALID) : `BIR_VEC_ZERO; // [R02] [R12]

   // disabled route contributes nothing
   assign drive    = target & {16{irq_in}};                          // [R13]

   // private line masks its isa source; pci overlap always masks it
   assign isa_mask = (share_w ? `BIR_VEC_ZERO : target)             // [R04]
                   | (target & pci_hit);                             // [R07]

endmodule : bir_route_dec
`default_nettype wire

// *** bir_steer.sv ***
// Behaviour
// R01: Two 8-bit read/write routing registers sit at offsets 70h and 71h, the second only on the older variant, both resetting to 80h.
// R02: Each board interrupt input is steered on its own to one of eleven controller request inputs.
// R03: Bit 7 low enables a route and bit 7 high, the reset state, disables it.
// R04: Bit 6 selects sharing, and with sharing off on an enabled route the selected isa line is masked.
// R05: Software enables sharing only when both devices on the line drive active-high level interrupts.
// R06: A board device sharing a target with a pci line must drive active-high level interrupts.
// R07: When a board route and a pci line hit the same target the isa line of that target is masked.
// R08: Software clears bit 6 of a route that shares its target with a pci line.
// R09: On the newer variant bit 5 of the first register turns the dual pin into the irq0 output.
// R10: The source of the ide interrupt status flag is irq15 with bit 5 set, else the first board input.
// R11: Bit 4 of each routing register is reserved and reads zero.
// R12: The 4-bit code names the target request input, codes 0-2, 8 and 13 being reserved.
// R13: With sharing on the board interrupt and the isa line are ORed, and a disabled route adds nothing.
`timescale 1ns/100ps
`default_nettype none
`include "bir_params.svh"

module bir_steer #(
   parameter bit NEWER_VARIANT = 1'b1
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   // configuration space access, function 0
   input  wire logic                  cfg_wr,
   input  wire logic                  cfg_rd,
   input  wire logic [7:0]            cfg_addr,
   input  wire logic [7:0]            cfg_wdata,
   output logic [7:0]                 cfg_rdata_r,
   output logic                       cfg_rvalid_r,
   // board interrupt pins, bit 0 is the dual function pin input
   input  wire logic [1:0]            board_irq_inputs,
   output logic                       dual_function_irq_pin_out_r,
   output logic                       dual_function_irq_pin_oe_n_r,
   // system timer level for the irq0 output
   input  wire logic                  timer_irq0,
   // isa interrupt pins
   input  wire bir_pkg::bir_irq_vec_t isa_irq,
   // request inputs claimed by pci steering
   input  wire bir_pkg::bir_irq_vec_t pci_irq_line_hit,
   // controller request inputs and ide flag source
   output bir_pkg::bir_irq_vec_t      pic_req_r,
   output logic                       ide_irq_src_r
);

   // ==========================================================
   // registers
   bir_pkg::bir_route_t   route_first_r;
   bir_pkg::bir_route_t   route_first_nxt;
   bir_pkg::bir_route_t   route_second_r;
   bir_pkg::bir_route_t   route_second_nxt;
   logic [1:0]            board_meta_r;
   logic [1:0]            board_sync_r;
   bir_pkg::bir_irq_vec_t isa_meta_r;
   bir_pkg::bir_irq_vec_t isa_sync_r;

   // ==========================================================
   // configuration decode
   wire                   hit_first_w;
   wire                   hit_second_w;
   wire bir_pkg::bir_route_t wr_mask_w;
   wire bir_pkg::bir_route_t rd_first_w;
   wire bir_pkg::bir_route_t rd_second_w;
   wire bir_pkg::bir_route_t rd_data_w;

   // reserved bit 4 never stored; bit 5 only where the dual pin exists
   assign wr_mask_w    = ~((8'h01 << `BIR_RSV_BIT)
                         | (NEWER_VARIANT ? 8'h00 : (8'h01 << `BIR_IRQ0_BIT))); // [R11]
   assign hit_first_w  = (cfg_addr == `BIR_OFF_ROUTE_FIRST);                    // [R01]
   assign hit_second_w = (cfg_addr == `BIR_OFF_ROUTE_SECOND) & ~NEWER_VARIANT;   // [R01]
   assign route_first_nxt  = (cfg_wr & hit_first_w) ? (cfg_wdata & wr_mask_w)
                                                     : route_first_r;
   assign route_second_nxt = (cfg_wr & hit_second_w) ? (cfg_wdata & wr_mask_w)
                                                      : route_second_r;
   assign rd_first_w   = route_first_r & wr_mask_w;                             // [R11]
   assign rd_second_w  = route_second_r & wr_mask_w;                            // [R11]
   assign rd_data_w    = hit_first_w  ? rd_first_w  :
                         hit_second_w ? rd_second_w : `BIR_READ_NONE;

   // routing registers, 80h after reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         route_first_r  <= `BIR_ROUTE_RST;                                    // [R01] [R03]
         route_second_r <= `BIR_ROUTE_RST;                                    // [R01]
      end else begin
         route_first_r  <= route_first_nxt;
         route_second_r <= route_second_nxt;
      end
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_rdata_r  <= `BIR_READ_NONE;
         cfg_rvalid_r <= 1'b0;
      end else begin
         cfg_rdata_r  <= cfg_rd ? rd_data_w : cfg_rdata_r;
         cfg_rvalid_r <= cfg_rd;
      end
   end

   // ==========================================================
   // pin synchronisers, first stage read only by the second
   always_ff @(posedge core_clk) begin
      if (reset) begin
         board_meta_r <= 2'b00;
         board_sync_r <= 2'b00;
         isa_meta_r   <= `BIR_VEC_ZERO;
         isa_sync_r   <= `BIR_VEC_ZERO;
      end else begin
         board_meta_r <= board_irq_inputs;
         board_sync_r <= board_meta_r;
         isa_meta_r   <= isa_irq;
         isa_sync_r   <= isa_meta_r;
      end
   end

   // ==========================================================
   // steering
   wire                   irq0_mode_w;
   wire                   first_irq_w;
   wire                   second_irq_w;
   wire bir_pkg::bir_route_t route_second_eff_w;
   wire bir_pkg::bir_irq_vec_t tgt_first_w;
   wire bir_pkg::bir_irq_vec_t tgt_second_w;
   wire bir_pkg::bir_irq_vec_t drv_first_w;
   wire bir_pkg::bir_irq_vec_t drv_second_w;
   wire bir_pkg::bir_irq_vec_t msk_first_w;
   wire bir_pkg::bir_irq_vec_t msk_second_w;
   wire bir_pkg::bir_irq_vec_t pic_req_nxt;
   wire                   ide_irq_src_nxt;

   // dual pin as output leaves no first board input to route
   assign irq0_mode_w  = NEWER_VARIANT & route_first_r[`BIR_IRQ0_BIT];          // [R09]
   assign first_irq_w  = board_sync_r[0] & ~irq0_mode_w;                        // [R09]
   assign second_irq_w = board_sync_r[1];
   // second route is absent on the newer variant: held disabled
   assign route_second_eff_w = NEWER_VARIANT ? `BIR_ROUTE_RST : route_second_r;

   bir_route_dec u_dec_first (
      .route    (route_first_r),
      .irq_in   (first_irq_w),
      .pci_hit  (pci_irq_line_hit),
      .target   (tgt_first_w),
      .drive    (drv_first_w),
      .isa_mask (msk_first_w)
   );

   bir_route_dec u_dec_second (
      .route    (route_second_eff_w),
      .irq_in   (second_irq_w),
      .pci_hit  (pci_irq_line_hit),
      .target   (tgt_second_w),
      .drive    (drv_second_w),
      .isa_mask (msk_second_w)
   );

   // masked isa lines ORed with routed board levels
   assign pic_req_nxt = (isa_sync_r & ~(msk_first_w | msk_second_w))          // [R04] [R07]
                      | drv_first_w | drv_second_w;                           // [R13]

   // ide flag source follows the dual pin mode
   assign ide_irq_src_nxt = irq0_mode_w ? isa_sync_r[`BIR_IRQ15_IDX]           // [R10]
                                        : board_sync_r[0];                    // [R10]

   // outputs registered
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pic_req_r                    <= `BIR_VEC_ZERO;
         ide_irq_src_r                <= 1'b0;
         dual_function_irq_pin_out_r  <= 1'b0;
         dual_function_irq_pin_oe_n_r <= 1'b1;
      end else begin
         pic_req_r                    <= pic_req_nxt;
         ide_irq_src_r                <= ide_irq_src_nxt;
         dual_function_irq_pin_out_r  <= timer_irq0 & irq0_mode_w;             // [R09]
         dual_function_irq_pin_oe_n_r <= ~irq0_mode_w;                          // [R09]
      end
   end

   // ==========================================================
   // checks
   default clocking bir_cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // register returns to 80h one cycle after reset
   route_reset_a: assert property (                                            // [R01]
      $fell(reset) |-> route_first_r == `BIR_ROUTE_RST)
      else $error("first route not at reset value");

   // written bit 7 reads back, with bit 4 clear
   readback_rsv_a: assert property (                                           // [R11]
      (cfg_wr && hit_first_w) ##1 (cfg_rd && hit_first_w && !cfg_wr)
      |=> cfg_rvalid_r && cfg_rdata_r[`BIR_RSV_BIT] == 1'b0
          && cfg_rdata_r[`BIR_EN_N_BIT] == $past(cfg_wdata[`BIR_EN_N_BIT], 2))
      else $error("route readback wrong");

   // disabled route never drives a request input
   disabled_route_a: assert property (                                         // [R03]
      route_first_r[`BIR_EN_N_BIT] |-> tgt_first_w == `BIR_VEC_ZERO)
      else $error("disabled route has a target");

   // reserved code targets nothing
   reserved_code_a: assert property (                                          // [R12]
      (route_first_r[3:0] < 4'h3 || route_first_r[3:0] == 4'h8 || route_first_r[3:0] == 4'hD)
      |-> tgt_first_w == `BIR_VEC_ZERO)
      else $error("reserved code routed");

   // private route: target follows the board level alone
   private_route_a: assert property (                                          // [R04]
      (!route_first_r[`BIR_EN_N_BIT] && !route_first_r[`BIR_SHARE_BIT]
       && route_first_r[3:0] == 4'h5 && route_second_eff_w[`BIR_EN_N_BIT])
      |=> pic_req_r[5] == $past(first_irq_w))
      else $error("private route not isolated");

   // shared route ORs isa and board levels
   shared_or_a: assert property (                                              // [R13]
      (!route_first_r[`BIR_EN_N_BIT] && route_first_r[`BIR_SHARE_BIT]
       && route_first_r[3:0] == 4'h9 && pci_irq_line_hit[9] == 1'b0
       && route_second_eff_w[`BIR_EN_N_BIT])
      |=> pic_req_r[9] == ($past(first_irq_w) | $past(isa_sync_r[9])))
      else $error("shared route not ORed");

   // pci overlap masks the isa line even with sharing set
   pci_overlap_a: assert property (                                            // [R07]
      ((tgt_first_w & pci_irq_line_hit) != `BIR_VEC_ZERO)
      |-> ((tgt_first_w & pci_irq_line_hit) & ~msk_first_w) == `BIR_VEC_ZERO)
      else $error("pci overlap not masked");

   // dual pin driven with the timer level in irq0 mode
   dual_pin_a: assert property (                                               // [R09]
      irq0_mode_w |=> !dual_function_irq_pin_oe_n_r
                      && dual_function_irq_pin_out_r == $past(timer_irq0))
      else $error("dual pin not driving irq0");

   // ide source follows irq15 in irq0 mode
   ide_source_a: assert property (                                             // [R10]
      irq0_mode_w |=> ide_irq_src_r == $past(isa_sync_r[`BIR_IRQ15_IDX]))
      else $error("ide source wrong");

endmodule : bir_steer
`default_nettype wire

// *** bir_pic_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// controller request inputs, level sensitive capture
module bir_pic_model (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   // request levels from the steering block
   input  wire bir_pkg::bir_irq_vec_t pic_req_r,
   // levels as the controller latched them
   output var bir_pkg::bir_irq_vec_t  req_seen_r
);
   // levels only, no edge memory, so a dropped request is seen at the next edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_seen_r <= 16'h0000;
      end else begin
         req_seen_r <= pic_req_r;
      end
   end
endmodule : bir_pic_model

`default_nettype wire

// *** test_board_irq_steering.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "bir_params.svh"

// ==========================================================
// bench for the board interrupt steering block
module test_board_irq_steering;
   localparam bir_pkg::bir_irq_vec_t VALID_CODES = 16'hDEF8;
   logic                  core_clk = 1'b0;
   logic                  reset = 1'b1;
   logic                  cfg_wr = 1'b0;
   logic                  cfg_rd = 1'b0;
   logic                  timer_irq0 = 1'b0;
   logic [7:0]            cfg_addr = 8'h00;
   logic [7:0]            cfg_wdata = 8'h00;
   logic [1:0]            board_irq_inputs = 2'h0;
   bir_pkg::bir_irq_vec_t isa_irq = 16'h0000;
   bir_pkg::bir_irq_vec_t pci_hit = 16'h0000;
   logic [7:0]            cfg_rdata_r;
   logic                  cfg_rvalid_r, pin_out, pin_oe_n, ide_irq_src_r;
   bir_pkg::bir_irq_vec_t pic_req_r, req_seen_r;
   bir_pkg::bir_route_t   rt;
   logic [7:0]            old_rdata;
   logic                  old_oe_n;
   bir_pkg::bir_irq_vec_t old_pic;
   int                    error_cnt = 0;
   int                    check_count = 0;
   int                    cyc = 0;

   bir_steer #(.NEWER_VARIANT(1'b1)) bir_steer_i (.core_clk(core_clk), .reset(reset),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r),
      .board_irq_inputs(board_irq_inputs), .dual_function_irq_pin_out_r(pin_out),
      .dual_function_irq_pin_oe_n_r(pin_oe_n), .timer_irq0(timer_irq0), .isa_irq(isa_irq),
      .pci_irq_line_hit(pci_hit), .pic_req_r(pic_req_r), .ide_irq_src_r(ide_irq_src_r));
   // older variant on the same bus and pins: second route and 71h live
   bir_steer #(.NEWER_VARIANT(1'b0)) bir_steer_old_i (.core_clk(core_clk), .reset(reset),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata_r(old_rdata), .cfg_rvalid_r(),
      .board_irq_inputs(board_irq_inputs), .dual_function_irq_pin_out_r(),
      .dual_function_irq_pin_oe_n_r(old_oe_n), .timer_irq0(timer_irq0), .isa_irq(isa_irq),
      .pci_irq_line_hit(pci_hit), .pic_req_r(old_pic), .ide_irq_src_r());
   bir_pic_model bir_pic_model_i (.core_clk(core_clk), .reset(reset), .pic_req_r(pic_req_r),
      .req_seen_r(req_seen_r));

   // clock and cycle ceiling
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge core_clk);
      cfg_wr = 1'b1;
      cfg_addr = addr;
      cfg_wdata = data;
      @(negedge core_clk);
      cfg_wr = 1'b0;
   endtask : cfg_write

   task automatic cfg_read(input logic [7:0] addr, input logic [7:0] exp);
      @(negedge core_clk);
      cfg_rd = 1'b1;
      cfg_addr = addr;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      check(cfg_rvalid_r === 1'b1 && cfg_rdata_r === exp, "config read data");
   endtask : cfg_read

   // write, then read the same offset at the very next edge
   task automatic cfg_write_read(input logic [7:0] addr, input logic [7:0] data,
         input logic [7:0] exp);
      @(negedge core_clk);
      cfg_wr = 1'b1;
      cfg_addr = addr;
      cfg_wdata = data;
      @(negedge core_clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b1;
      @(negedge core_clk);
      cfg_rd = 1'b0;
      check(cfg_rvalid_r === 1'b1 && cfg_rdata_r === exp, "write then read");
   endtask : cfg_write_read

   // expected controller inputs, all sixteen lines
   function automatic bir_pkg::bir_irq_vec_t exp_req(input bir_pkg::bir_route_t r,
         input logic brd, input bir_pkg::bir_irq_vec_t isa, input bir_pkg::bir_irq_vec_t pci);
      bir_pkg::bir_irq_vec_t tgt;
      bir_pkg::bir_irq_vec_t msk;
      tgt = (!r[7] && VALID_CODES[r[3:0]]) ? (16'h0001 << r[3:0]) : 16'h0000;
      msk = (!r[6] || (tgt & pci) != 16'h0000) ? tgt : 16'h0000;
      return (isa & ~msk) | ((brd && !r[5]) ? tgt : 16'h0000);
   endfunction : exp_req

   // program a route, hold levels steady, then look at every output
   task automatic apply(input bir_pkg::bir_route_t r, input logic brd,
         input bir_pkg::bir_irq_vec_t isa, input bir_pkg::bir_irq_vec_t pci);
      board_irq_inputs = {1'b0, brd};
      isa_irq = isa;
      pci_hit = pci;
      cfg_write(`BIR_OFF_ROUTE_FIRST, r);
      repeat (5) @(negedge core_clk);
      check(pic_req_r === exp_req(r, brd, isa, pci), "steered requests");
      check(req_seen_r === exp_req(r, brd, isa, pci), "latched requests");
      check(ide_irq_src_r === (r[5] ? isa[15] : brd), "ide flag source");
      check(pin_oe_n === !r[5] && pin_out === (r[5] & timer_irq0), "dual pin");
      cfg_read(`BIR_OFF_ROUTE_FIRST, r & 8'hEF);
   endtask : apply

   initial begin
      void'($urandom(96734));
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      cfg_read(8'h70, 8'h80);
      cfg_read(8'h72, 8'h00);
      cfg_write(8'h71, 8'h05);
      cfg_read(8'h71, 8'h00);
      cfg_write_read(`BIR_OFF_ROUTE_FIRST, 8'h5A, 8'h4A);
      // every code, exclusive then shared then disabled
      for (int c = 0; c < 16; c++) begin
         apply({4'h0, c[3:0]}, 1'b1, 16'hFFFF, 16'h0000);
         apply({4'h5, c[3:0]}, 1'b1, 16'h0000, 16'h0000);
         apply({4'h9, c[3:0]}, 1'b1, 16'hFFFF, 16'h0000);
      end
      // software clears sharing when pci claims the target
      apply(8'h0B, 1'b1, 16'hFFFF, 16'h0800);
      timer_irq0 = 1'b1;
      apply(8'h25, 1'b1, 16'h8000, 16'h0000);
      apply(8'h2E, 1'b0, 16'h0000, 16'h0000);
      for (int n = 0; n < 60; n++) begin
         rt = bir_pkg::bir_route_t'($urandom);
         pci_hit = bir_pkg::bir_irq_vec_t'($urandom);
         if (pci_hit[rt[3:0]]) begin
            rt[6] = 1'b0;
         end
         timer_irq0 = 1'($urandom);
         apply(rt, 1'($urandom), bir_pkg::bir_irq_vec_t'($urandom), pci_hit);
      end
      // second reset in mid-run
      @(negedge core_clk);
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      check(pic_req_r === 16'h0000 && pin_oe_n === 1'b1 && ide_irq_src_r === 1'b0, "reset outputs");
      cfg_read(8'h70, 8'h80);
      // older variant: second route live, bit 5 never stored
      board_irq_inputs = 2'b10;
      isa_irq = 16'h0000;
      pci_hit = 16'h0000;
      cfg_write(`BIR_OFF_ROUTE_SECOND, 8'h2A);
      repeat (5) @(negedge core_clk);
      check(old_pic === 16'h0400, "older second route");
      cfg_read(`BIR_OFF_ROUTE_SECOND, 8'h00);
      check(old_rdata === 8'h0A, "older second readback");
      cfg_write(`BIR_OFF_ROUTE_FIRST, 8'h25);
      cfg_read(`BIR_OFF_ROUTE_FIRST, 8'h25);
      check(old_rdata === 8'h05 && old_oe_n === 1'b1, "older bit 5");
      tally_and_finish();
   end
endmodule : test_board_irq_steering

`default_nettype wire
